// >>> src/twi_rd_master.sv
// Purpose: Two-wire bus master issuing EEPROM reads.
// Assumes: Single master; slave never stretches SCL.
// Notes: SCL is divided from the system clock in quarters.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_rd_consts.svh"
module twi_rd_master (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   twi_if.master bus,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic i_cmd_random,
   input wire logic [2:0] i_cmd_dev,
   input wire logic [6:0] i_cmd_addr,
   input wire logic [7:0] i_cmd_len,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   input wire logic i_rd_ready,
   output logic o_nack,
   output logic o_busy
);
   eeprom_rd_pkg::mst_s st_q;
   eeprom_rd_pkg::mst_s st_d;
   logic stall;
   logic last;

   assign last = st_q.bits == `BYTE_BITS;
   // Full buffer holds SCL low before the ack slot
   assign stall = st_q.st == eeprom_rd_pkg::M_RX && last &&
                  st_q.ph == `PH_DRIVE && st_q.fcnt == `FIFO_DEPTH;

   always_comb begin
      logic tick;
      logic push;
      logic pop;
      tick = 1'h0;
      push = 1'h0;
      pop = o_rd_valid & i_rd_ready;
      st_d = st_q;
      st_d.sda_m = bus.sda;
      st_d.sda_s = st_q.sda_m;
      st_d.nack = 1'h0;
      if (st_q.st != eeprom_rd_pkg::M_IDLE && !stall) begin
         if (st_q.qc == `QTR_MAX) begin
            st_d.qc = '0;
            tick = 1'h1;
            st_d.ph = st_q.ph + 2'h1;
         end else begin
            st_d.qc = st_q.qc + 5'h1;
         end
      end
      unique case (st_q.st)
         eeprom_rd_pkg::M_IDLE: if (i_cmd_valid) begin
            st_d.dev = i_cmd_dev;
            st_d.waddr = i_cmd_addr;
            st_d.left = i_cmd_len;
            if (!i_cmd_random && i_cmd_len == '0) begin
               st_d.left = 8'h1;
            end
            st_d.kind = i_cmd_random ? eeprom_rd_pkg::K_DEVW :
                        eeprom_rd_pkg::K_DEVR;
            st_d.st = eeprom_rd_pkg::M_START;
            st_d.ph = `PH_DRIVE;
            st_d.qc = '0;
         end
         eeprom_rd_pkg::M_START: if (tick) begin
            unique case (st_q.ph)
               `PH_DRIVE: st_d.oe_n = 1'h1;
               `PH_RISE: st_d.scl = 1'h1;
               `PH_SAMPLE: st_d.oe_n = 1'h0;
               `PH_FALL: begin
                  st_d.scl = 1'h0;
                  st_d.st = eeprom_rd_pkg::M_TX;
                  st_d.bits = '0;
                  st_d.sh = {`DEV_TYPE_CODE, st_q.dev,
                     st_q.kind == eeprom_rd_pkg::K_DEVR ?
                     `DIR_READ : `DIR_WRITE};
               end
            endcase
         end
         eeprom_rd_pkg::M_TX: if (tick) begin
            unique case (st_q.ph)
               `PH_DRIVE: st_d.oe_n = last ? 1'h1 : st_q.sh[7];
               `PH_RISE: st_d.scl = 1'h1;
               `PH_SAMPLE: if (last) st_d.ackd = ~st_q.sda_s;
               `PH_FALL: begin
                  st_d.scl = 1'h0;
                  if (!last) begin
                     st_d.sh = {st_q.sh[6:0], 1'h0};
                     st_d.bits = st_q.bits + 4'h1;
                  end else if (!st_q.ackd) begin
                     st_d.nack = 1'h1;
                     st_d.st = eeprom_rd_pkg::M_STOP;
                  end else begin
                     unique case (st_q.kind)
                        eeprom_rd_pkg::K_DEVW: begin
                           st_d.kind = eeprom_rd_pkg::K_WADDR;
                           st_d.sh = {1'h0, st_q.waddr};
                           st_d.bits = '0;
                        end
                        eeprom_rd_pkg::K_WADDR: begin
                           if (st_q.left == '0) begin
                              st_d.st = eeprom_rd_pkg::M_STOP;
                           end else begin
                              st_d.kind = eeprom_rd_pkg::K_DEVR;
                              st_d.st = eeprom_rd_pkg::M_START;
                           end
                        end
                        eeprom_rd_pkg::K_DEVR: begin
                           st_d.st = eeprom_rd_pkg::M_RX;
                           st_d.bits = '0;
                        end
                        default: st_d.st = eeprom_rd_pkg::M_STOP;
                     endcase
                  end
               end
            endcase
         end
         eeprom_rd_pkg::M_RX: if (tick) begin
            unique case (st_q.ph)
               `PH_DRIVE: begin
                  if (last) begin
                     push = 1'h1;
                     // Ack all but the final byte
                     st_d.oe_n = st_q.left == 8'h1;
                     st_d.left = st_q.left - 8'h1;
                  end else begin
                     st_d.oe_n = 1'h1;
                  end
               end
               `PH_RISE: st_d.scl = 1'h1;
               `PH_SAMPLE: if (!last) begin
                  st_d.sh = {st_q.sh[6:0], st_q.sda_s};
               end
               `PH_FALL: begin
                  st_d.scl = 1'h0;
                  if (!last) begin
                     st_d.bits = st_q.bits + 4'h1;
                  end else if (st_q.left == '0) begin
                     st_d.st = eeprom_rd_pkg::M_STOP;
                  end else begin
                     st_d.bits = '0;
                  end
               end
            endcase
         end
         eeprom_rd_pkg::M_STOP: if (tick) begin
            unique case (st_q.ph)
               `PH_DRIVE: st_d.oe_n = 1'h0;
               `PH_RISE: st_d.scl = 1'h1;
               `PH_SAMPLE: st_d.oe_n = 1'h1;
               `PH_FALL: st_d.st = eeprom_rd_pkg::M_IDLE;
            endcase
         end
         default: st_d.st = eeprom_rd_pkg::M_IDLE;
      endcase
      if (push) begin
         st_d.fb[st_q.fwr] = st_q.sh;
         st_d.fwr = ~st_q.fwr;
      end
      if (pop) begin
         st_d.frd = ~st_q.frd;
      end
      st_d.fcnt = st_q.fcnt + {1'h0, push} - {1'h0, pop};
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= '0;
         st_q.scl <= `LINE_IDLE;
         st_q.oe_n <= `LINE_IDLE;
         st_q.sda_m <= `LINE_IDLE;
         st_q.sda_s <= `LINE_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.scl = st_q.scl;
   assign bus.m_sda_o = 1'h0;
   assign bus.m_sda_oe_n = st_q.oe_n;
   assign o_cmd_ready = st_q.st == eeprom_rd_pkg::M_IDLE;
   assign o_busy = st_q.st != eeprom_rd_pkg::M_IDLE;
   assign o_rd_valid = st_q.fcnt != '0;
   assign o_rd_data = st_q.fb[st_q.frd];
   assign o_nack = st_q.nack;
endmodule : twi_rd_master
`default_nettype wire

// >>> src/eeprom_rd_consts.svh
// Purpose: Shared constants of the serial EEPROM read link.
// Assumes: 20 MHz system clock on both ends.
// Notes: Definitions only.
`ifndef EEPROM_RD_CONSTS_SVH
`define EEPROM_RD_CONSTS_SVH

// Device type code; value is arbitrary
`define DEV_TYPE_CODE 4'h5
`define DIR_READ 1'h1
`define DIR_WRITE 1'h0
`define BYTE_BITS 4'h8
`define LINE_IDLE 1'h1
`define FIFO_DEPTH 2'h2

`define SYS_CLK_NS 50
`define SCL_PERIOD_NS 2600
`define QTR_CYC ((`SCL_PERIOD_NS / 4 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define QTR_MAX 5'(`QTR_CYC - 1)

// Quarters of one SCL period
`define PH_DRIVE 2'h0
`define PH_RISE 2'h1
`define PH_SAMPLE 2'h2
`define PH_FALL 2'h3

`endif

// >>> src/eeprom_rd_pkg.sv
// Purpose: Types of the serial EEPROM read link.
// Assumes: Nothing.
// Notes: One state struct per end.
package eeprom_rd_pkg;

   typedef enum logic [2:0] {
      S_IDLE, S_DEV, S_WADDR, S_WDATA, S_ACK, S_TX, S_TX_ACK
   } slv_st_e;

   typedef struct packed {
      slv_st_e st;
      slv_st_e nxt;
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic [2:0] cs_m;
      logic [2:0] cs_s;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [6:0] cnt;
      logic oe_n;
      logic sel;
      logic [127:0][7:0] mem;
   } slv_s;

   typedef enum logic [2:0] {
      M_IDLE, M_START, M_TX, M_RX, M_STOP
   } mst_st_e;

   typedef enum logic [1:0] {K_DEVW, K_WADDR, K_DEVR} tx_kind_e;

   typedef struct packed {
      mst_st_e st;
      tx_kind_e kind;
      logic [4:0] qc;
      logic [1:0] ph;
      logic [3:0] bits;
      logic [7:0] sh;
      logic scl;
      logic oe_n;
      logic sda_m;
      logic sda_s;
      logic ackd;
      logic [6:0] waddr;
      logic [2:0] dev;
      logic [7:0] left;
      logic nack;
      logic [1:0][7:0] fb;
      logic fwr;
      logic frd;
      logic [1:0] fcnt;
   } mst_s;

endpackage : eeprom_rd_pkg

// >>> src/twi_if.sv
// Purpose: Two-wire link between bus master and EEPROM slave.
// Assumes: SDA has a pull-up; SCL is driven by the master only.
// Notes: Enables are low while a party pulls SDA.
`timescale 1ns/1ps
`default_nettype none
interface twi_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic sda;

   // Wired AND with pull-up
   assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

   modport master (output scl, output m_sda_o, output m_sda_oe_n,
                   input sda);
   modport slave (input scl, input sda, output s_sda_o,
                  output s_sda_oe_n);
endinterface : twi_if
`default_nettype wire

// >>> src/eeprom_rd_slave.sv
// Purpose: Read engine of a 128-byte serial EEPROM slave.
// Assumes: Bus master owns SCL; SDA is open drain with pull-up.
// Notes: Write data is acknowledged and counted but not stored.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_rd_consts.svh"
module eeprom_rd_slave (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   twi_if.slave bus,
   input wire logic [2:0] i_chip_select_straps,
   input wire logic i_load_valid,
   input wire logic [6:0] i_load_addr,
   input wire logic [7:0] i_load_data,
   output logic [6:0] o_word_addr,
   output logic o_selected
);
   eeprom_rd_pkg::slv_s st_q;
   eeprom_rd_pkg::slv_s st_d;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic addr_match;
   logic byte_done;

   // Edges seen only after two-stage synchronisers
   assign scl_rise = st_q.scl_s & ~st_q.scl_p;
   assign scl_fall = ~st_q.scl_s & st_q.scl_p;
   // SCL must be high in both samples so a late SCL edge is not misread
   assign bus_start = st_q.scl_s & st_q.scl_p & st_q.sda_p &
                      ~st_q.sda_s;
   assign bus_stop = st_q.scl_s & st_q.scl_p & ~st_q.sda_p &
                     st_q.sda_s;
   assign addr_match = st_q.sh[7:4] == `DEV_TYPE_CODE &&
                       st_q.sh[3:1] == st_q.cs_s;
   // Eighth fall hands the line over to the ack slot
   assign byte_done = scl_fall && st_q.bits == `BYTE_BITS;

   always_comb begin
      logic load_byte;
      load_byte = 1'h0;
      st_d = st_q;
      st_d.scl_m = bus.scl;
      st_d.scl_s = st_q.scl_m;
      st_d.scl_p = st_q.scl_s;
      st_d.sda_m = bus.sda;
      st_d.sda_s = st_q.sda_m;
      st_d.sda_p = st_q.sda_s;
      st_d.cs_m = i_chip_select_straps;
      st_d.cs_s = st_q.cs_m;
      // Backdoor preload only; the link has no write path
      if (i_load_valid) begin
         st_d.mem[i_load_addr] = i_load_data;
      end
      if (bus_start) begin
         st_d.st = eeprom_rd_pkg::S_DEV;
         st_d.bits = '0;
         st_d.oe_n = 1'h1;
         st_d.sel = 1'h0;
      end else if (bus_stop) begin
         st_d.st = eeprom_rd_pkg::S_IDLE;
         st_d.oe_n = 1'h1;
         st_d.sel = 1'h0;
      end else begin
         unique case (st_q.st)
            eeprom_rd_pkg::S_IDLE: begin
               // Off the bus until a start is seen
               st_d.oe_n = 1'h1;
            end
            eeprom_rd_pkg::S_DEV: begin
               if (scl_rise) begin
                  st_d.sh = {st_q.sh[6:0], st_q.sda_s};
                  st_d.bits = st_q.bits + 4'h1;
               end else if (byte_done) begin
                  st_d.bits = '0;
                  if (addr_match) begin
                     st_d.sel = 1'h1;
                     st_d.oe_n = 1'h0;
                     st_d.st = eeprom_rd_pkg::S_ACK;
                     if (st_q.sh[0] == `DIR_READ) begin
                        st_d.nxt = eeprom_rd_pkg::S_TX;
                     end else begin
                        st_d.nxt = eeprom_rd_pkg::S_WADDR;
                     end
                  end else begin
                     // Another device was addressed; stay off the bus
                     st_d.st = eeprom_rd_pkg::S_IDLE;
                  end
               end
            end
            eeprom_rd_pkg::S_WADDR: begin
               if (scl_rise) begin
                  st_d.sh = {st_q.sh[6:0], st_q.sda_s};
                  st_d.bits = st_q.bits + 4'h1;
               end else if (byte_done) begin
                  st_d.bits = '0;
                  // Top bit ignored: 128 locations only
                  st_d.cnt = st_q.sh[6:0];
                  st_d.oe_n = 1'h0;
                  st_d.st = eeprom_rd_pkg::S_ACK;
                  st_d.nxt = eeprom_rd_pkg::S_WDATA;
               end
            end
            eeprom_rd_pkg::S_WDATA: begin
               if (scl_rise) begin
                  st_d.sh = {st_q.sh[6:0], st_q.sda_s};
                  st_d.bits = st_q.bits + 4'h1;
               end else if (byte_done) begin
                  st_d.bits = '0;
                  st_d.cnt = st_q.cnt + 7'h1;
                  st_d.oe_n = 1'h0;
                  st_d.st = eeprom_rd_pkg::S_ACK;
                  st_d.nxt = eeprom_rd_pkg::S_WDATA;
               end
            end
            eeprom_rd_pkg::S_ACK: begin
               // Ack held through the ninth clock, dropped on its fall
               if (scl_fall) begin
                  if (st_q.nxt == eeprom_rd_pkg::S_TX) begin
                     load_byte = 1'h1;
                  end else begin
                     st_d.oe_n = 1'h1;
                     st_d.st = st_q.nxt;
                  end
               end
            end
            eeprom_rd_pkg::S_TX: begin
               if (scl_fall) begin
                  if (st_q.bits == `BYTE_BITS) begin
                     st_d.oe_n = 1'h1;
                     st_d.st = eeprom_rd_pkg::S_TX_ACK;
                  end else begin
                     st_d.sh = {st_q.sh[6:0], 1'h0};
                     st_d.oe_n = st_q.sh[6];
                     st_d.bits = st_q.bits + 4'h1;
                  end
               end
            end
            eeprom_rd_pkg::S_TX_ACK: begin
               // Sampled on the rise, where the master's level is settled
               if (scl_rise && st_q.sda_s) begin
                  st_d.st = eeprom_rd_pkg::S_IDLE;
                  st_d.sel = 1'h0;
               end else if (scl_fall) begin
                  load_byte = 1'h1;
               end
            end
            default: begin
               st_d.st = eeprom_rd_pkg::S_IDLE;
               st_d.oe_n = 1'h1;
            end
         endcase
      end
      if (load_byte) begin
         // First bit goes out on the same falling edge
         st_d.sh = st_q.mem[st_q.cnt];
         st_d.oe_n = st_q.mem[st_q.cnt][7];
         st_d.bits = 4'h1;
         // Seven-bit counter rolls over from the top by itself
         st_d.cnt = st_q.cnt + 7'h1;
         st_d.st = eeprom_rd_pkg::S_TX;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= '0;
         // Lines reset to idle high so no false start follows reset
         st_q.oe_n <= `LINE_IDLE;
         st_q.scl_m <= `LINE_IDLE;
         st_q.scl_s <= `LINE_IDLE;
         st_q.scl_p <= `LINE_IDLE;
         st_q.sda_m <= `LINE_IDLE;
         st_q.sda_s <= `LINE_IDLE;
         st_q.sda_p <= `LINE_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.s_sda_o = 1'h0;
   assign bus.s_sda_oe_n = st_q.oe_n;
   assign o_word_addr = st_q.cnt;
   assign o_selected = st_q.sel;
endmodule : eeprom_rd_slave
`default_nettype wire

// >>> test/eeprom_rd_link_sva.sv
// Purpose: Link checks of the EEPROM read engine between both ends.
// Assumes: Link lines are launched from the system clock domain.
// Notes: Bit and byte positions are counted from each start.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_rd_consts.svh"
module eeprom_rd_link_sva (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic scl,
   input wire logic sda,
   input wire logic s_sda_oe_n,
   input wire logic [2:0] i_chip_select_straps
);
   logic scl_q, sda_q, busy_q, sel_q, rd_q, done_q;
   logic [3:0] nbit_q;
   logic [7:0] nbyte_q, sh_q;
   logic start, stop, rise, ninth, match;

   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   assign rise = scl && !scl_q;
   assign ninth = rise && (nbit_q == 4'h8);
   assign match = (sh_q[7:1] == {`DEV_TYPE_CODE, i_chip_select_straps});

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         busy_q <= 1'h0;
         sel_q <= 1'h0;
         rd_q <= 1'h0;
         done_q <= 1'h0;
         nbit_q <= 4'h0;
         nbyte_q <= 8'h0;
         sh_q <= 8'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start || stop) begin
            busy_q <= start;
            nbit_q <= 4'h0;
            nbyte_q <= 8'h0;
            sel_q <= 1'h0;
            done_q <= 1'h0;
         end else if (rise) begin
            sh_q <= {sh_q[6:0], sda};
            if (nbit_q == 4'h8) begin
               nbit_q <= 4'h0;
               nbyte_q <= nbyte_q + 8'h1;
               if (nbyte_q == 8'h0) begin
                  sel_q <= match && !sda;
                  rd_q <= sh_q[0];
               end else if (sel_q && rd_q && sda) begin
                  done_q <= 1'h1;
               end
            end else begin
               nbit_q <= nbit_q + 4'h1;
            end
         end
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_ninth_addr;
      ninth && (nbyte_q == 8'h0);
   endsequence
   sequence s_ninth_data;
      ninth && (nbyte_q != 8'h0) && sel_q;
   endsequence

   a_idle_scl_high: assert property (!busy_q |-> scl)
      else $error("bus clock low while link idle");
   a_idle_quiet: assert property (!busy_q |-> s_sda_oe_n)
      else $error("slave pulls data while link idle");
   // Slave edges must trail a clock fall by a short sync lag only
   a_slave_scl_low: assert property (
      $changed(s_sda_oe_n) |-> !scl && $past(scl, 7))
      else $error("slave data changed away from clock fall");
   a_addr_released: assert property (
      rise && nbyte_q == 8'h0 && nbit_q != 4'h8 |-> s_sda_oe_n)
      else $error("slave drove data during address byte");
   a_addr_ack: assert property (
      s_ninth_addr ##0 match |-> !s_sda_oe_n)
      else $error("matching address not acknowledged");
   a_addr_refuse: assert property (
      s_ninth_addr ##0 !match |-> s_sda_oe_n)
      else $error("foreign address acknowledged");
   a_rx_ack: assert property (
      s_ninth_data ##0 !rd_q |-> !s_sda_oe_n)
      else $error("received word address not acknowledged");
   a_tx_release: assert property (
      s_ninth_data ##0 rd_q |-> s_sda_oe_n)
      else $error("slave held data in acknowledge slot");
   a_nack_release: assert property (done_q |-> s_sda_oe_n)
      else $error("slave drove data after missing acknowledge");
endmodule : eeprom_rd_link_sva
`default_nettype wire

// >>> test/tb_serial_eeprom_read_engine.sv
// Purpose: Self-checking bench of master and slave joined by the link.
// Assumes: Memory is preloaded by the backdoor port.
// Notes: Expected bytes follow a fixed address pattern.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      checks++; \
      if ((g) !== (e)) begin \
         errors++; \
         $display("[ERR] %s exp %0h got %0h", nm, e, g); \
      end \
   end
module tb_serial_eeprom_read_engine;
   logic clk, rstn, cmd_valid, cmd_random, rd_ready, load_valid;
   logic cmd_ready, rd_valid, nack, busy, selected;
   logic [2:0] cmd_dev, straps;
   logic [6:0] cmd_addr, load_addr, word_addr, ctr;
   logic [7:0] cmd_len, load_data, rd_data;
   int errors, checks, cyc, nacks, n;

   twi_if link();
   twi_rd_master twi_rd_master_i (.i_sys_clk(clk), .i_rstn(rstn),
      .bus(link), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
      .i_cmd_random(cmd_random), .i_cmd_dev(cmd_dev),
      .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .o_rd_valid(rd_valid),
      .o_rd_data(rd_data), .i_rd_ready(rd_ready), .o_nack(nack),
      .o_busy(busy));
   eeprom_rd_slave eeprom_rd_slave_i (.i_sys_clk(clk), .i_rstn(rstn),
      .bus(link), .i_chip_select_straps(straps),
      .i_load_valid(load_valid), .i_load_addr(load_addr),
      .i_load_data(load_data), .o_word_addr(word_addr),
      .o_selected(selected));
   eeprom_rd_link_sva eeprom_rd_link_sva_i (.i_sys_clk(clk), .i_rstn(rstn),
      .scl(link.scl), .sda(link.sda), .s_sda_oe_n(link.s_sda_oe_n),
      .i_chip_select_straps(straps));

   always #25 clk = ~clk;

   function automatic logic [7:0] exp_byte(input logic [6:0] a);
      return {a, 1'h0} ^ 8'h96;
   endfunction : exp_byte

   task automatic close_out();
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // One read command; ok low means no slave should answer
   task automatic run(input logic rnd, input logic [2:0] dev,
         input logic [6:0] adr, input logic [7:0] len, input int stall,
         input logic ok);
      logic [6:0] a;
      int w;
      a = rnd ? adr : ctr;
      @(negedge clk);
      cmd_valid = 1'h1;
      cmd_random = rnd;
      cmd_dev = dev;
      cmd_addr = adr;
      cmd_len = len;
      @(negedge clk);
      cmd_valid = 1'h0;
      `CHK("busy", 1'h1, busy)
      for (int i = 0; i < (ok ? int'(len) : 0); i++) begin
         w = 0;
         while (rd_valid !== 1'h1 && w < 4000) begin
            @(negedge clk);
            w++;
         end
         // Long stall fills both buffer entries and parks the clock
         if (i == 0) repeat (stall) @(negedge clk);
         if (i == 0) `CHK("selected", 1'h1, selected)
         `CHK("rd_data", exp_byte(a), rd_data)
         rd_ready = 1'h1;
         @(negedge clk);
         rd_ready = 1'h0;
         a = a + 7'h1;
      end
      w = 0;
      while (busy === 1'h1 && w < 8000) begin
         @(negedge clk);
         w++;
      end
      // Slave sees the stop a sync lag later
      repeat (6) @(negedge clk);
      `CHK("busy", 1'h0, busy)
      if (ok) ctr = a;
      `CHK("word_addr", ctr, word_addr)
      `CHK("selected", 1'h0, selected)
   endtask : run

   always @(negedge clk) begin
      if (nack === 1'h1) nacks++;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      clk = 1'h0;
      rstn = 1'h0;
      cmd_valid = 1'h0;
      cmd_random = 1'h0;
      cmd_dev = 3'h0;
      cmd_addr = 7'h0;
      cmd_len = 8'h0;
      rd_ready = 1'h0;
      load_valid = 1'h0;
      load_addr = 7'h0;
      load_data = 8'h0;
      straps = 3'h0;
      ctr = 7'h0;
      repeat (5) @(negedge clk);
      rstn = 1'h1;
      `CHK("word_addr", 7'h0, word_addr)
      `CHK("cmd_ready", 1'h1, cmd_ready)
      for (int a = 0; a < 128; a++) begin
         load_valid = 1'h1;
         load_addr = 7'(a);
         load_data = exp_byte(7'(a));
         @(negedge clk);
      end
      load_valid = 1'h0;
      run(1'h0, 3'h0, 7'h0, 8'h1, 0, 1'h1);
      run(1'h0, 3'h0, 7'h0, 8'h2, 0, 1'h1);
      run(1'h1, 3'h0, 7'h28, 8'h4, 1500, 1'h1);
      run(1'h1, 3'h0, 7'h7e, 8'h4, 0, 1'h1);
      run(1'h1, 3'h0, 7'h09, 8'h0, 0, 1'h1);
      run(1'h0, 3'h0, 7'h0, 8'h1, 0, 1'h1);
      n = nacks;
      run(1'h0, 3'h1, 7'h0, 8'h1, 0, 1'h0);
      `CHK("nack", n + 1, nacks)
      for (int s = 1; s < 8; s++) begin
         straps = 3'(s);
         repeat (4) @(negedge clk);
         run(1'h1, 3'(s), 7'(s * 17), 8'h1, 0, 1'h1);
      end
      close_out();
   end
endmodule : tb_serial_eeprom_read_engine
`default_nettype wire
